// ===== verilog/pclw_link.sv
// Word-command interpreter: parses framed ASCII commands, drives the register port,
// and forms OK, data or error answers through a two-entry output buffer.
// Assumes i_reg_rdata is valid in the same cycle that o_reg.re is high.
`timescale 1ns/1ns
module pclw_link (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [15:0] i_station,
   input wire logic i_cksum_en,
   input wire pclw_pkg::pclw_byte_t i_rx,
   output logic o_rx_ready,
   output pclw_pkg::pclw_byte_t o_tx,
   input wire logic i_tx_ready,
   output pclw_pkg::pclw_regreq_t o_reg,
   input wire logic [15:0] i_reg_rdata
);
   typedef enum logic [3:0] {
      P_IDLE, P_HDR, P_REG, P_DLM, P_CNT, P_DATA, P_CKS, P_ETX, P_CR, P_DRAIN,
      T_HEAD, T_RD, T_RW, T_HEX, T_CKS, T_END
   } pclw_st_t;

   typedef struct packed {
      pclw_st_t st;
      pclw_st_t after;
      pclw_pkg::pclw_cmd_t cmd;
      logic [3:0] pos;
      logic [6:0] cnt;
      logic [6:0] idx;
      logic [15:0] acc;
      logic [15:0] base;
      logic [15:0] sta;
      logic [15:0] cpu;
      logic [15:0] op;
      logic ign;
      logic [15:0] err;
      logic [pclw_pkg::LIST_N-1:0][15:0] lst;
      logic [pclw_pkg::MON_N-1:0][15:0] mon;
      logic [4:0] mon_n;
      logic [7:0] sum;
      logic [15:0] word;
      logic rdy;
      pclw_pkg::pclw_regreq_t rg;
   } pclw_link_st_t;

   pclw_link_st_t q;
   pclw_link_st_t d;
   logic take;
   logic is_dec;
   logic is_hex;
   logic is_dlm;
   logic [3:0] nib;
   logic [15:0] acc_dec;
   logic [15:0] acc_hex;
   logic [6:0] lim;
   logic last;
   logic [15:0] ecode;
   logic push_v;
   logic [7:0] push_b;
   logic push_ok;
   pclw_st_t tail;
   logic cont;
   logic tx_v;
   logic [7:0] tx_b;

   pclw_ascii u_ascii (
      .i_ch(i_rx.b),
      .o_dec(is_dec),
      .o_hex(is_hex),
      .o_dlm(is_dlm),
      .o_nib(nib)
   );

   pclw_buf2 #(.W(8)) u_buf (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_sv(push_v),
      .i_sd(push_b),
      .o_sr(push_ok),
      .o_mv(tx_v),
      .o_md(tx_b),
      .i_mr(i_tx_ready)
   );

   assign take = q.rdy && i_rx.v;
   assign acc_dec = q.acc * 16'h000A + {12'h000, nib};
   assign acc_hex = {q.acc[11:0], nib};
   assign last = (q.idx + 7'h01) == q.cnt;
   // Checksum characters sit before ETX only when the link runs with a checksum.
   assign tail = i_cksum_en ? P_CKS : P_ETX;
   assign cont = (q.cmd == pclw_pkg::CONTIGUOUS_WORD_WRITE) ||
                 (q.cmd == pclw_pkg::CONTIGUOUS_WORD_READ);
   assign lim = cont ? pclw_pkg::CONT_MAX :
                (q.cmd == pclw_pkg::MONITOR_LIST_DEFINE) ? pclw_pkg::MON_MAX :
                pclw_pkg::RAND_MAX;

   always_comb begin
      d = q;
      d.rg.we = 1'b0;
      d.rg.re = 1'b0;
      ecode = pclw_pkg::ERR_NONE;
      push_v = 1'b0;
      push_b = 8'h00;
      unique case (q.st)
         P_IDLE: begin
         end
         P_HDR: if (take) begin
            d.pos = q.pos + 4'h1;
            unique case (q.pos)
               4'h0: d.sta[15:8] = i_rx.b;
               4'h1: d.sta[7:0] = i_rx.b;
               4'h2: d.cpu[15:8] = i_rx.b;
               4'h3: d.cpu[7:0] = i_rx.b;
               4'h5, 4'h6: d.op = {q.op[7:0], i_rx.b};
               default: begin
               end
            endcase
            if (q.pos == pclw_pkg::HDR_LAST) begin
               d.pos = 4'h0;
               d.acc = 16'h0000;
               d.ign = q.sta != i_station;
               unique case ({q.op, i_rx.b})
                  pclw_pkg::NAME_CONT_WR: d.cmd = pclw_pkg::CONTIGUOUS_WORD_WRITE;
                  pclw_pkg::NAME_CONT_RD: d.cmd = pclw_pkg::CONTIGUOUS_WORD_READ;
                  pclw_pkg::NAME_RAND_RD: d.cmd = pclw_pkg::RANDOM_WORD_READ;
                  pclw_pkg::NAME_RAND_WR: d.cmd = pclw_pkg::RANDOM_WORD_WRITE;
                  pclw_pkg::NAME_MON_DEF: d.cmd = pclw_pkg::MONITOR_LIST_DEFINE;
                  pclw_pkg::NAME_MON_RD: d.cmd = pclw_pkg::MONITOR_LIST_READ;
                  default: d.cmd = pclw_pkg::NO_COMMAND;
               endcase
               unique case (d.cmd)
                  pclw_pkg::NO_COMMAND: ecode = pclw_pkg::ERR_SYNTAX;
                  pclw_pkg::CONTIGUOUS_WORD_WRITE: d.st = P_REG;
                  pclw_pkg::CONTIGUOUS_WORD_READ: d.st = P_REG;
                  pclw_pkg::MONITOR_LIST_READ: d.st = tail;
                  default: d.st = P_CNT;
               endcase
               if (d.ign) begin
                  d.st = P_DRAIN;
               end
            end
         end
         P_REG: if (take) begin
            d.pos = q.pos + 4'h1;
            if (q.pos != 4'h0) begin
               d.acc = acc_dec;
               if (!is_dec) begin
                  ecode = pclw_pkg::ERR_SYNTAX;
               end
            end
            if (q.pos == pclw_pkg::REG_LAST) begin
               d.pos = 4'h0;
               d.acc = 16'h0000;
               d.st = P_DLM;
               if (cont) begin
                  d.base = acc_dec;
                  d.after = P_CNT;
               end else if (q.cmd == pclw_pkg::RANDOM_WORD_WRITE) begin
                  d.base = acc_dec;
                  d.after = P_DATA;
               end else begin
                  d.lst[q.idx[4:0]] = acc_dec;
                  d.idx = q.idx + 7'h01;
                  d.after = P_REG;
                  if (last) begin
                     d.st = tail;
                  end
               end
            end
         end
         P_DLM: if (take) begin
            d.st = q.after;
            if (!is_dlm) begin
               ecode = pclw_pkg::ERR_SYNTAX;
            end
         end
         P_CNT: if (take) begin
            d.pos = q.pos + 4'h1;
            d.acc = acc_dec;
            if (!is_dec) begin
               ecode = pclw_pkg::ERR_SYNTAX;
            end
            if (q.pos == pclw_pkg::CNT_LAST) begin
               d.pos = 4'h0;
               d.acc = 16'h0000;
               d.cnt = acc_dec[6:0];
               // Counts outside the per-command range are refused before any write.
               if (acc_dec == 16'h0000 || acc_dec > {9'h000, lim}) begin
                  ecode = pclw_pkg::ERR_COUNT;
               end
               unique case (q.cmd)
                  pclw_pkg::CONTIGUOUS_WORD_WRITE: begin
                     d.st = P_DLM;
                     d.after = P_DATA;
                  end
                  pclw_pkg::CONTIGUOUS_WORD_READ: d.st = tail;
                  default: d.st = P_REG;
               endcase
            end
         end
         P_DATA: if (take) begin
            d.pos = q.pos + 4'h1;
            d.acc = acc_hex;
            if (!is_hex) begin
               ecode = pclw_pkg::ERR_SYNTAX;
            end
            if (q.pos == pclw_pkg::DAT_LAST) begin
               d.pos = 4'h0;
               d.acc = 16'h0000;
               d.rg.we = 1'b1;
               d.rg.wdata = acc_hex;
               d.rg.addr = cont ? q.base + {9'h000, q.idx} : q.base;
               d.idx = q.idx + 7'h01;
               d.st = cont ? P_DATA : P_DLM;
               d.after = P_REG;
               if (last) begin
                  d.st = tail;
               end
            end
         end
         P_CKS: if (take) begin
            d.pos = q.pos + 4'h1;
            if (q.pos == pclw_pkg::CNT_LAST) begin
               d.pos = 4'h0;
               d.st = P_ETX;
            end
         end
         P_ETX: if (take) begin
            d.st = P_CR;
            if (i_rx.b != pclw_pkg::CH_ETX) begin
               ecode = pclw_pkg::ERR_SYNTAX;
            end
         end
         P_CR: if (take) begin
            if (i_rx.b != pclw_pkg::CH_CR) begin
               ecode = pclw_pkg::ERR_SYNTAX;
            end else begin
               d.st = T_HEAD;
               d.pos = 4'h0;
               d.idx = 7'h00;
               d.sum = 8'h00;
               if (q.cmd == pclw_pkg::MONITOR_LIST_DEFINE) begin
                  d.mon = q.lst[pclw_pkg::MON_N-1:0];
                  d.mon_n = q.cnt[4:0];
               end
               if (q.cmd == pclw_pkg::MONITOR_LIST_READ) begin
                  d.cnt = {2'h0, q.mon_n};
                  if (q.mon_n == 5'h00) begin
                     d.err = pclw_pkg::ERR_NOLIST;
                  end
               end
            end
         end
         P_DRAIN: if (take && i_rx.b == pclw_pkg::CH_CR) begin
            d.st = q.ign ? P_IDLE : T_HEAD;
            d.pos = 4'h0;
            d.sum = 8'h00;
         end
         T_HEAD: begin
            push_v = 1'b1;
            unique case (q.pos)
               4'h0: push_b = pclw_pkg::CH_STX;
               4'h1: push_b = q.sta[15:8];
               4'h2: push_b = q.sta[7:0];
               4'h3: push_b = q.cpu[15:8];
               4'h4: push_b = q.cpu[7:0];
               4'h5: push_b = (q.err != 16'h0000) ? pclw_pkg::CH_E : pclw_pkg::CH_O;
               4'h6: push_b = (q.err != 16'h0000) ? pclw_pkg::CH_R : pclw_pkg::CH_K;
               4'h7: push_b = q.err[15:8];
               default: push_b = q.err[7:0];
            endcase
            if (push_ok) begin
               d.pos = q.pos + 4'h1;
               if (q.pos != 4'h0) begin
                  d.sum = q.sum + push_b;
               end
               if (q.err != 16'h0000 ? q.pos == pclw_pkg::ERR_LAST :
                   q.pos == pclw_pkg::OK_LAST) begin
                  d.pos = 4'h0;
                  d.st = i_cksum_en ? T_CKS : T_END;
                  if (q.err == 16'h0000 && (q.cmd == pclw_pkg::CONTIGUOUS_WORD_READ ||
                      q.cmd == pclw_pkg::RANDOM_WORD_READ ||
                      q.cmd == pclw_pkg::MONITOR_LIST_READ)) begin
                     d.st = T_RD;
                  end
               end
            end
         end
         T_RD: begin
            d.rg.re = 1'b1;
            d.st = T_RW;
            unique case (q.cmd)
               pclw_pkg::CONTIGUOUS_WORD_READ: d.rg.addr = q.base + {9'h000, q.idx};
               pclw_pkg::MONITOR_LIST_READ: d.rg.addr = q.mon[q.idx[4:0]];
               default: d.rg.addr = q.lst[q.idx[4:0]];
            endcase
         end
         T_RW: begin
            d.word = i_reg_rdata;
            d.st = T_HEX;
            d.pos = 4'h0;
         end
         T_HEX: begin
            push_v = 1'b1;
            push_b = pclw_pkg::pclw_nib2asc(q.word[15:12]);
            if (push_ok) begin
               d.sum = q.sum + push_b;
               d.word = {q.word[11:0], 4'h0};
               d.pos = q.pos + 4'h1;
               if (q.pos == pclw_pkg::DAT_LAST) begin
                  d.pos = 4'h0;
                  d.idx = q.idx + 7'h01;
                  d.st = last ? (i_cksum_en ? T_CKS : T_END) : T_RD;
               end
            end
         end
         T_CKS: begin
            push_v = 1'b1;
            push_b = pclw_pkg::pclw_nib2asc(q.pos[0] ? q.sum[3:0] : q.sum[7:4]);
            if (push_ok) begin
               d.pos = q.pos + 4'h1;
               if (q.pos[0]) begin
                  d.pos = 4'h0;
                  d.st = T_END;
               end
            end
         end
         T_END: begin
            push_v = 1'b1;
            push_b = q.pos[0] ? pclw_pkg::CH_CR : pclw_pkg::CH_ETX;
            if (push_ok) begin
               d.pos = q.pos + 4'h1;
               if (q.pos[0]) begin
                  d.st = P_IDLE;
               end
            end
         end
      endcase
      if (ecode != pclw_pkg::ERR_NONE) begin
         d.err = ecode;
         d.st = P_DRAIN;
      end
      // A fresh STX always restarts the parser, so a broken frame cannot wedge it.
      if (take && i_rx.b == pclw_pkg::CH_STX) begin
         d.st = P_HDR;
         d.pos = 4'h0;
         d.idx = 7'h00;
         d.ign = 1'b0;
         d.err = pclw_pkg::ERR_NONE;
      end
      d.rdy = d.st < T_HEAD;
   end

   // Reset stands for power-up: the monitor list and its length return to empty.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_rx_ready = q.rdy;
   assign o_reg = q.rg;
   assign o_tx = '{v: tx_v, b: tx_b};

   default clocking @(posedge i_mclk iff i_ce);
   endclocking
   default disable iff (i_rst);

   ign_no_write_a: assert property (q.ign |-> !o_reg.we && !push_v)
      else $error("ignored frame caused a write or answer");
   cont_addr_a: assert property ((q.st == P_DATA && take && q.pos == 4'h3 && cont)
      |=> o_reg.we && o_reg.addr == q.base + {9'h000, q.idx} - 16'h0001)
      else $error("contiguous write address wrong");
   cont_count_a: assert property (q.st == P_DATA && cont |-> q.cnt >= 7'h01 &&
      q.cnt <= pclw_pkg::CONT_MAX)
      else $error("contiguous write count out of range");
   hex_nib_a: assert property ((q.st == P_DATA && take && is_hex && q.pos == 4'h0)
      |=> q.acc[3:0] == $past(nib))
      else $error("hex digit not collected");
   ok_letter_a: assert property ((q.st == T_HEAD && q.pos == 4'h5 && q.err == 16'h0000)
      |-> push_v && push_b == pclw_pkg::CH_O)
      else $error("OK answer malformed");
   rd_capture_a: assert property (o_reg.re |=> q.st == T_HEX &&
      q.word == $past(i_reg_rdata))
      else $error("read word not captured");
   rand_addr_a: assert property ((q.st == T_RD && q.cmd == pclw_pkg::RANDOM_WORD_READ)
      |=> o_reg.re && o_reg.addr == q.lst[q.idx[4:0]])
      else $error("random read address wrong");
   mon_empty_a: assert property ((q.st == T_HEAD && q.cmd == pclw_pkg::MONITOR_LIST_READ &&
      q.mon_n == 5'h00) |-> q.err == pclw_pkg::ERR_NOLIST)
      else $error("empty monitor list not refused");
   mon_nodata_a: assert property (q.st == T_RD |->
      q.cmd != pclw_pkg::MONITOR_LIST_DEFINE)
      else $error("list define returned data");
   mon_size_a: assert property (q.mon_n <= pclw_pkg::MON_MAX[4:0])
      else $error("monitor list too long");
endmodule

// ===== verilog/pclw_pkg.sv
// Shared constants and carrier types for the word-command link interpreter.
// Assumes a byte stream of ASCII characters in and out, one byte per handshake.
// Contract
// - Contiguous write: start register, delimiter, count, delimiter, then consecutive data words.
// - Contiguous write count must be one to sixty-four, else invalid.
// - Each data word is four ASCII hex digits forming one 16-bit word.
// - Successful write or list define answers STX, address, CPU number, OK, ETX, CR.
// - Without checksum the two checksum characters are absent from commands.
// - Random read: count one to thirty-two, then register numbers split by delimiters.
// - Read answers OK then each word as four hex digits, request order.
// - Random read returns individually addressed, possibly scattered registers.
// - Random write count is one to thirty-two; no more pairs are taken.
// - Random write entries are register, delimiter, four hex digits, delimited.
// - Monitor list define carries one to twenty-four register numbers.
// - Monitor list define only stores the list and answers OK without data.
// - The monitor list is volatile and empty after every power-up.
// - Monitor read with no stored list answers error code 06.
// - Monitor read returns stored registers in list order, up to twenty-four.
// - Contiguous read: start register and count one to sixty-four, consecutive values.
package pclw_pkg;
   localparam logic [7:0] CH_STX = 8'h02;
   localparam logic [7:0] CH_ETX = 8'h03;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_COMMA = 8'h2C;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_O = 8'h4F;
   localparam logic [7:0] CH_K = 8'h4B;
   localparam logic [7:0] CH_E = 8'h45;
   localparam logic [7:0] CH_R = 8'h52;
   localparam logic [23:0] NAME_CONT_WR = 24'h575752;
   localparam logic [23:0] NAME_CONT_RD = 24'h575244;
   localparam logic [23:0] NAME_RAND_RD = 24'h575252;
   localparam logic [23:0] NAME_RAND_WR = 24'h575257;
   localparam logic [23:0] NAME_MON_DEF = 24'h575253;
   localparam logic [23:0] NAME_MON_RD = 24'h57524D;
   localparam logic [3:0] HDR_LAST = 4'h7;
   localparam logic [3:0] REG_LAST = 4'h4;
   localparam logic [3:0] DAT_LAST = 4'h3;
   localparam logic [3:0] CNT_LAST = 4'h1;
   localparam logic [3:0] OK_LAST = 4'h6;
   localparam logic [3:0] ERR_LAST = 4'h8;
   localparam logic [6:0] CONT_MAX = 7'h40;
   localparam logic [6:0] RAND_MAX = 7'h20;
   localparam logic [6:0] MON_MAX = 7'h18;
   localparam int LIST_N = 32;
   localparam int MON_N = 24;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_SYNTAX = 16'h3032;
   localparam logic [15:0] ERR_COUNT = 16'h3033;
   localparam logic [15:0] ERR_NOLIST = 16'h3036;

   typedef enum logic [2:0] {
      NO_COMMAND,
      CONTIGUOUS_WORD_WRITE,
      CONTIGUOUS_WORD_READ,
      RANDOM_WORD_READ,
      RANDOM_WORD_WRITE,
      MONITOR_LIST_DEFINE,
      MONITOR_LIST_READ
   } pclw_cmd_t;

   typedef struct packed {
      logic v;
      logic [7:0] b;
   } pclw_byte_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pclw_regreq_t;

   function automatic logic [7:0] pclw_nib2asc(input logic [3:0] n);
      pclw_nib2asc = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction
endpackage

// ===== verilog/pclw_ascii.sv
// Character classifier for the command parser: digit, hex digit, delimiter.
// Assumes upper-case hex letters only; lower case is treated as a bad character.
`timescale 1ns/1ns
module pclw_ascii (
   input wire logic [7:0] i_ch,
   output logic o_dec,
   output logic o_hex,
   output logic o_dlm,
   output logic [3:0] o_nib
);
   logic is_af;

   always_comb begin
      o_dec = (i_ch >= 8'h30) && (i_ch <= 8'h39);
      is_af = (i_ch >= 8'h41) && (i_ch <= 8'h46);
      o_hex = o_dec || is_af;
      o_dlm = (i_ch == pclw_pkg::CH_COMMA) || (i_ch == pclw_pkg::CH_SPACE);
      o_nib = o_dec ? i_ch[3:0] : i_ch[3:0] + 4'h9;
   end
endmodule

// ===== verilog/pclw_buf2.sv
// Two-entry buffer between the answer former and the serial transmitter.
// Assumes the drain side may stall at any time; the fill side sees ready drop when full.
`timescale 1ns/1ns
module pclw_buf2 #(
   parameter int W = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_sv,
   input wire logic [W-1:0] i_sd,
   output logic o_sr,
   output logic o_mv,
   output logic [W-1:0] o_md,
   input wire logic i_mr
);
   typedef struct packed {
      logic hv;
      logic [W-1:0] hd;
      logic sv;
      logic [W-1:0] sd;
   } pclw_buf_st_t;

   pclw_buf_st_t q;
   pclw_buf_st_t d;

   if (W < 1) begin : g_chk
      $error("pclw_buf2 needs a positive width");
   end

   // The head register drives the outputs directly; the spare catches a word when held.
   always_comb begin
      d = q;
      if (q.hv && i_mr) begin
         d.hv = 1'b0;
      end
      if (!d.hv && q.sv) begin
         d.hv = 1'b1;
         d.hd = q.sd;
         d.sv = 1'b0;
      end
      if (i_sv && !q.sv) begin
         if (!d.hv) begin
            d.hv = 1'b1;
            d.hd = i_sd;
         end else begin
            d.sv = 1'b1;
            d.sd = i_sd;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_sr = !q.sv;
   assign o_mv = q.hv;
   assign o_md = q.hd;
endmodule

// ===== dv/pclw_host.sv
// Host model: sends framed commands byte by byte and collects answer bytes.
// Assumes the bench calls send, get and take from one sequence.
`timescale 1ns/1ns
module pclw_host (
   input wire logic i_mclk,
   input wire logic i_rx_ready,
   input wire pclw_pkg::pclw_byte_t i_tx,
   input wire logic i_stall,
   output pclw_pkg::pclw_byte_t o_rx,
   output logic o_tx_ready
);
   logic [7:0] q[$];
   logic [1:0] ph_q = 2'h0;
   initial o_rx = '{v: 1'b0, b: 8'hFF};
   initial o_tx_ready = 1'b1;
   // A stalling host still takes one byte in four, so every answer drains.
   always @(posedge i_mclk) begin
      ph_q <= ph_q + 2'h1;
      o_tx_ready <= !i_stall || ph_q == 2'h3;
      if (i_tx.v && o_tx_ready) q.push_back(i_tx.b);
   end
   task automatic put(input logic [7:0] c);
      o_rx <= '{v: 1'b1, b: c};
      do @(posedge i_mclk); while (i_rx_ready !== 1'b1);
   endtask
   task automatic send(input string body, input string cks);
      @(posedge i_mclk);
      put(8'h02);
      foreach (body[i]) put(body[i]);
      foreach (cks[i]) put(cks[i]);
      put(8'h03);
      put(8'h0D);
      // The released line shows the inverse of the last byte, not a stale copy.
      o_rx <= '{v: 1'b0, b: 8'hF2};
   endtask
   task automatic take(output string r);
      r = "";
      foreach (q[i]) r = $sformatf("%s%c", r, q[i]);
      q.delete();
   endtask
   task automatic get(output string r);
      int n;
      n = 0;
      while (n < 3000 && !(q.size() > 0 && q[$] == 8'h0D)) begin
         @(posedge i_mclk);
         n++;
      end
      take(r);
   endtask
endmodule

// ===== dv/pclw_link_bench.sv
// Bench for the word-command interpreter: a table of frames and answers,
// then reset, checksum and foreign-station cases.
// Assumes a plain 16-bit register memory behind the register port.
`timescale 1ns/1ns
module pclw_link_bench;
   typedef struct {
      string cmd;
      string rsp;
   } pclw_row_t;
   logic mclk;
   logic rst;
   logic cks_en;
   logic stall;
   logic rx_ready;
   logic tx_ready;
   pclw_pkg::pclw_byte_t rx;
   pclw_pkg::pclw_byte_t tx;
   pclw_pkg::pclw_regreq_t regq;
   logic [15:0] mem [0:1023];
   wire logic [15:0] rdata = mem[regq.addr[9:0]];
   int fail_count = 0;
   int n_checks = 0;
   string got;
   pclw_row_t rows [0:11] = '{
      '{"01010WRM", "0101ER06"},
      '{"01010WWRD0043,02,03800000", "0101OK"},
      '{"01010WRDD0043,02", "0101OK03800000"},
      '{"01010WWRD0010 01 FFFF", "0101OK"},
      '{"01010WRW02D0104,0014 D0105,0005", "0101OK"},
      '{"01010WRR03D0105,D0010 D0043", "0101OK0005FFFF0380"},
      '{"01010WRS02D0104,D0044", "0101OK"},
      '{"01010WRM", "0101OK00140000"},
      '{"01010WWRD0001,65,0000", "0101ER03"},
      '{"01010WRR33D0001", "0101ER03"},
      '{"01010WRW00D0001,0000", "0101ER03"},
      '{"01010WRS25D0001", "0101ER03"}
   };

   pclw_link dut_u (
      .i_mclk(mclk), .i_rst(rst), .i_ce(1'b1), .i_station(16'h3031),
      .i_cksum_en(cks_en), .i_rx(rx), .o_rx_ready(rx_ready), .o_tx(tx),
      .i_tx_ready(tx_ready), .o_reg(regq), .i_reg_rdata(rdata)
   );
   pclw_host host_u (
      .i_mclk(mclk), .i_rx_ready(rx_ready), .i_tx(tx), .i_stall(stall),
      .o_rx(rx), .o_tx_ready(tx_ready)
   );

   always @(posedge mclk) begin
      if (regq.we) mem[regq.addr[9:0]] <= regq.wdata;
   end

   task automatic chk_str(input string what, input string exp, input string seen);
      n_checks++;
      if (exp != seen) begin
         fail_count++;
         $display("MISMATCH %s expected %s seen %s", what, exp, seen);
      end
   endtask
   task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   function automatic string wrap(input string s);
      return {"\002", s, "\003\015"};
   endfunction
   function automatic string cks(input string s);
      logic [7:0] sum;
      sum = 8'h00;
      foreach (s[i]) sum = sum + s[i];
      return $sformatf("%02X", sum);
   endfunction
   task automatic do_reset();
      rst <= 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
   endtask

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      rst = 1'b1;
      cks_en = 1'b0;
      stall = 1'b0;
      do_reset();
      foreach (rows[i]) begin
         // Odd rows stall the answer side to exercise the output buffer.
         stall <= i[0];
         host_u.send(rows[i].cmd, "");
         host_u.get(got);
         chk_str(rows[i].cmd, wrap(rows[i].rsp), got);
         $display("test %0d done", i);
      end
      chk_word("register 10", 16'hFFFF, mem[10]);
      do_reset();
      host_u.send("01010WRM", "");
      host_u.get(got);
      chk_str("list after reset", wrap("0101ER06"), got);
      $display("test reset done");
      cks_en <= 1'b1;
      host_u.send("01010WRDD0043,01", "00");
      host_u.get(got);
      chk_str("checksum frame", wrap({"0101OK0380", cks("0101OK0380")}), got);
      cks_en <= 1'b0;
      $display("test checksum done");
      host_u.send("02010WRM", "");
      repeat (60) @(posedge mclk);
      host_u.take(got);
      chk_str("foreign station", "", got);
      host_u.send("01010WRDD0044,01", "");
      host_u.get(got);
      chk_str("after foreign", wrap("0101OK0000"), got);
      $display("test foreign done");
      final_report();
   end
   initial begin
      #300000;
      fail_count++;
      final_report();
   end
endmodule
